// ===== shared/dpis_pkg.sv
/*
 * Shared constants and types for the parallel-input converter front end:
 * sample width, FIFO depth, clock rate, sleep timing, reset values, states.
 * Assumes a single 10 MHz clock and an active-low asynchronous reset.
 */
// What this block does
// - sample word is 14-bit unsigned binary
// - all-ones code gives full scale on true output
// - complement output carries inverse of true output while awake; asleep both are zero
// - input word captured by edge-triggered register only
// - output updates after every UPDATE_DIV-th rising edge (each edge at the default of 1)
// - any clock duty cycle meeting pulse width works
// - sleep high turns output current off
// - open sleep input reads low via pull-down
// - power down one cycle (100 ns) after synchronised sleep rises, up 5 us
`default_nettype none
package dpis_pkg;

    // sample word
    localparam int DATA_W = 14;
    localparam int FIFO_DEPTH = 32;

    // clock and sleep timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_DOWN_NS = 50;
    localparam int T_UP_NS = 5000;
    // longest time rounds down, floor of one cycle
    localparam int DOWN_CYC = (T_DOWN_NS / CLK_PERIOD_NS < 1) ? 1 : T_DOWN_NS / CLK_PERIOD_NS;
    // least time rounds up
    localparam int UP_CYC = (T_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UP_CNT_W = 7;

    // reset values of the output codes
    localparam logic [DATA_W-1:0] RST_LEVEL = 14'h0000;
    localparam logic [DATA_W-1:0] RST_LEVEL_N = 14'h3fff;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE = 2'b10
    } dpis_state_t;

    localparam dpis_state_t RST_STATE = ST_WAKE;

endpackage : dpis_pkg
`default_nettype wire

// ===== hw/dpis_sync2.sv
/*
 * Two-flop level synchroniser for pins that arrive from outside the clock.
 * Assumes the input holds each level for more than one clock period.
 */
`timescale 1ns/10ps
`default_nettype none
module dpis_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pin side
    input wire logic [W-1:0] d,
    // synchronised side
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } dpis_sync_state_t;

    dpis_sync_state_t s;
    dpis_sync_state_t next_s;

    always_comb begin
        next_s.meta = d;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.stable;

endmodule : dpis_sync2
`default_nettype wire

// ===== hw/dpis_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock; full refuses writes, empty refuses reads.
 */
`timescale 1ns/10ps
`default_nettype none
module dpis_fifo #(
    parameter int W = 14,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // fill side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } dpis_fifo_state_t;

    dpis_fifo_state_t s;
    dpis_fifo_state_t next_s;
    logic push;
    logic pop;

    // wraps for any depth, not only powers of two
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    assign in_ready = (s.count != FULL);
    assign out_valid = (s.count != '0);
    assign out_data = s.mem[s.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            // word is taken only at the edge, never in between
            next_s.mem[s.wr_ptr] = in_data;
            next_s.wr_ptr = bump(s.wr_ptr);
        end
        if (pop) begin
            next_s.rd_ptr = bump(s.rd_ptr);
        end
        if (push && !pop) begin
            next_s.count = s.count + 1'b1;
        end else if (pop && !push) begin
            next_s.count = s.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    push_count_a: assert property (@(posedge clk) disable iff (!rst_b)
        (push && !pop) |=> (s.count == $past(s.count) + 1'b1))
        else $error("fifo count did not grow on a lone push");

    full_refuse_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.count == FULL) |-> !in_ready)
        else $error("fifo accepts while full");

endmodule : dpis_fifo
`default_nettype wire

// ===== hw/dpis_top.sv
/*
 * Digital front end of a 14-bit current-output converter: captures the
 * parallel sample word on the rising clock, buffers it, and drives the
 * true and complement output codes; a sleep pin powers the outputs down.
 * Assumes the source drives data synchronous to clk and holds it
 * under src_valid until src_ready; the sleep pin is asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
module dpis_top #(
    parameter int UPDATE_DIV = 1,
    parameter int FIFO_DEPTH = dpis_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // sample source
    input wire logic [dpis_pkg::DATA_W-1:0] src_data,
    input wire logic src_valid,
    output logic src_ready,
    // sleep pin, with the far end's drive enable
    input wire logic sleep_in,
    input wire logic sleep_drive_en,
    // converter outputs
    output logic [dpis_pkg::DATA_W-1:0] true_current_output,
    output logic [dpis_pkg::DATA_W-1:0] complement_current_output,
    output logic output_enabled,
    output logic low_power,
    output logic sample_valid
);

    localparam int DW = dpis_pkg::DATA_W;
    localparam int CW = dpis_pkg::UP_CNT_W;
    localparam int DIV_W = (UPDATE_DIV > 1) ? $clog2(UPDATE_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(UPDATE_DIV - 1);
    localparam logic [CW-1:0] UP_LAST = CW'(dpis_pkg::UP_CYC - 1);
    localparam int UP_WAIT = dpis_pkg::UP_CYC;
    localparam int DOWN_WAIT = dpis_pkg::DOWN_CYC;

    typedef struct packed {
        dpis_pkg::dpis_state_t st;
        logic [CW-1:0] up_cnt;
        logic [DIV_W-1:0] div_cnt;
        logic [DW-1:0] level;
        logic [DW-1:0] level_n;
        logic on;
        logic lowp;
        logic valid;
        logic [CW-1:0] wake_cyc;
    } dpis_top_state_t;

    dpis_top_state_t s;
    dpis_top_state_t next_s;

    logic sleep_pin;
    logic sleep_s;
    logic update_en;
    logic drain;
    logic pop;
    logic [DW-1:0] fifo_data;
    logic fifo_valid;

    // undriven pin reads low, so the part stays enabled
    assign sleep_pin = sleep_in && sleep_drive_en;

    dpis_sync2 #(
        .W(1)
    ) u_sleep_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(sleep_pin),
        .q(sleep_s)
    );

    // storage is edge-triggered: data moving between edges is never seen
    dpis_fifo #(
        .W(DW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_data(src_data),
        .in_valid(src_valid),
        .in_ready(src_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(drain)
    );

    // only the rising edge matters, so duty cycle does not
    assign update_en = (s.div_cnt == '0);
    // asleep the drain stalls, so the fifo fills and pushes back
    assign drain = update_en && (s.st != dpis_pkg::ST_SLEEP);
    assign pop = drain && fifo_valid;

    always_comb begin
        next_s = s;
        next_s.div_cnt = update_en ? DIV_LAST : s.div_cnt - 1'b1;
        next_s.wake_cyc = (s.st == dpis_pkg::ST_WAKE) ? s.wake_cyc + 1'b1 : '0;
        unique case (s.st)
            dpis_pkg::ST_ACTIVE: begin
                if (sleep_s) begin
                    next_s.st = dpis_pkg::ST_SLEEP;
                end
            end
            dpis_pkg::ST_SLEEP: begin
                if (!sleep_s) begin
                    next_s.st = dpis_pkg::ST_WAKE;
                    next_s.up_cnt = UP_LAST;
                end
            end
            dpis_pkg::ST_WAKE: begin
                if (sleep_s) begin
                    next_s.st = dpis_pkg::ST_SLEEP;
                end else if (s.up_cnt == '0) begin
                    next_s.st = dpis_pkg::ST_ACTIVE;
                end else begin
                    next_s.up_cnt = s.up_cnt - 1'b1;
                end
            end
            default: begin
                next_s.st = dpis_pkg::ST_SLEEP;
            end
        endcase
        next_s.on = (next_s.st != dpis_pkg::ST_SLEEP);
        next_s.lowp = (next_s.st == dpis_pkg::ST_SLEEP);
        // samples are flagged invalid through the power-up interval
        next_s.valid = (next_s.st == dpis_pkg::ST_ACTIVE);
        if (next_s.st == dpis_pkg::ST_SLEEP) begin
            // both outputs carry no current while asleep
            next_s.level = '0;
            next_s.level_n = '0;
        end else if (pop) begin
            next_s.level = fifo_data;
            next_s.level_n = ~fifo_data;
        end else if (s.st == dpis_pkg::ST_SLEEP) begin
            // come back at code zero until a word arrives
            next_s.level = '0;
            next_s.level_n = '1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s.st <= dpis_pkg::RST_STATE;
            s.up_cnt <= UP_LAST;
            s.div_cnt <= '0;
            s.level <= dpis_pkg::RST_LEVEL;
            s.level_n <= dpis_pkg::RST_LEVEL_N;
            s.on <= 1'b1;
            s.lowp <= 1'b0;
            s.valid <= 1'b0;
            s.wake_cyc <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign true_current_output = s.level;
    assign complement_current_output = s.level_n;
    assign output_enabled = s.on;
    assign low_power = s.lowp;
    assign sample_valid = s.valid;

    full_scale_a: assert property (@(posedge clk) disable iff (!rst_b)
        (pop && fifo_data == '1 && !sleep_s && s.st == dpis_pkg::ST_ACTIVE)
        |=> (true_current_output == '1 && complement_current_output == '0))
        else $error("all-ones word did not give full scale");

    complement_a: assert property (@(posedge clk) disable iff (!rst_b)
        output_enabled |-> (complement_current_output == ~true_current_output))
        else $error("complement output is not the inverse");

    hold_between_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == dpis_pkg::ST_ACTIVE && !pop && !sleep_s)
        |=> $stable(true_current_output))
        else $error("output moved without a captured word");

    update_edge_a: assert property (@(posedge clk) disable iff (!rst_b)
        (pop && !sleep_s) |=> (true_current_output == $past(fifo_data)))
        else $error("output not updated from the popped word");

    update_rate_a: assert property (@(posedge clk) disable iff (!rst_b)
        update_en |=> (s.div_cnt == DIV_LAST))
        else $error("update divider lost its period");

    sleep_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        (sleep_s && s.st != dpis_pkg::ST_SLEEP)
        |=> (!output_enabled && low_power && true_current_output == '0
            && complement_current_output == '0))
        else $error("sleep did not switch the current off");

    pull_down_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!sleep_drive_en) [*3] |-> !sleep_s)
        else $error("open sleep pin did not read as awake");

    power_down_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(sleep_s) |-> ##DOWN_WAIT !output_enabled)
        else $error("power-down took too long");

    power_up_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == dpis_pkg::ST_ACTIVE && $past(s.st) == dpis_pkg::ST_WAKE)
        |-> (s.wake_cyc == CW'(UP_WAIT) && sample_valid))
        else $error("power-up interval has the wrong length");

    wake_invalid_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == dpis_pkg::ST_WAKE) |-> !sample_valid)
        else $error("sample flagged valid during power-up");

    sleep_flags_a: assert property (@(posedge clk) disable iff (!rst_b)
        low_power
        |-> (!output_enabled && !sample_valid))
        else $error("sleep flags disagree");

    sleep_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        low_power
        |-> (true_current_output == '0 && complement_current_output == '0))
        else $error("current flows while asleep");

    awake_flags_a: assert property (@(posedge clk) disable iff (!rst_b)
        !low_power
        |-> output_enabled)
        else $error("awake but output disabled");

    sleep_stays_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == dpis_pkg::ST_SLEEP && sleep_s)
        |=> (s.st == dpis_pkg::ST_SLEEP))
        else $error("left sleep while pin held high");

    sleep_stall_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == dpis_pkg::ST_SLEEP)
        |-> !pop)
        else $error("word drained while asleep");

    wake_cut_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == dpis_pkg::ST_WAKE && sleep_s)
        |=> (s.st == dpis_pkg::ST_SLEEP && low_power))
        else $error("sleep during power-up ignored");

    wake_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == dpis_pkg::ST_SLEEP && !sleep_s)
        |=> (s.st == dpis_pkg::ST_WAKE && s.up_cnt == UP_LAST))
        else $error("power-up did not start with a full count");

    wake_codes_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == dpis_pkg::ST_SLEEP && !sleep_s)
        |=> (true_current_output == '0 && complement_current_output == '1))
        else $error("codes wrong on leaving sleep");

    wake_count_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == dpis_pkg::ST_WAKE && !sleep_s && s.up_cnt != '0)
        |=> (s.st == dpis_pkg::ST_WAKE && s.up_cnt == $past(s.up_cnt) - 1'b1))
        else $error("power-up counter skipped");

    wake_end_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == dpis_pkg::ST_WAKE && !sleep_s && s.up_cnt == '0)
        |=> (s.st == dpis_pkg::ST_ACTIVE && sample_valid))
        else $error("power-up did not end at count zero");

    wake_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == dpis_pkg::ST_WAKE)
        |-> (s.wake_cyc < CW'(UP_WAIT)))
        else $error("power-up ran past its interval");

    valid_active_a: assert property (@(posedge clk) disable iff (!rst_b)
        sample_valid
        |-> (s.st == dpis_pkg::ST_ACTIVE))
        else $error("valid outside the active state");

    active_stays_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == dpis_pkg::ST_ACTIVE && !sleep_s)
        |=> (s.st == dpis_pkg::ST_ACTIVE && sample_valid))
        else $error("left active state while awake");

    state_legal_a: assert property (@(posedge clk) disable iff (!rst_b)
        1'b1
        |-> (s.st inside {dpis_pkg::ST_ACTIVE, dpis_pkg::ST_SLEEP, dpis_pkg::ST_WAKE}))
        else $error("state register holds an illegal code");

    ready_empty_a: assert property (@(posedge clk) disable iff (!rst_b)
        !fifo_valid
        |-> src_ready)
        else $error("empty buffer refuses words");

    ready_full_a: assert property (@(posedge clk) disable iff (!rst_b)
        !src_ready
        |-> fifo_valid)
        else $error("buffer refuses words with nothing stored");

    code_inverse_a: assert property (@(posedge clk) disable iff (!rst_b)
        (pop && !sleep_s)
        |=> (complement_current_output == ~$past(fifo_data)))
        else $error("complement not the inverse of the popped word");

    wake_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.st == dpis_pkg::ST_WAKE && !pop && !sleep_s)
        |=> $stable(true_current_output))
        else $error("output moved during power-up without a word");

endmodule : dpis_top
`default_nettype wire

// ===== bench/dpis_source.sv
/*
 * Sample source model: drives words under valid/ready and the sleep pin.
 * Assumes its tasks are called at a falling edge of clk.
 */
`timescale 1ns/10ps
`default_nettype none
module dpis_source (
    // clock
    input wire logic clk,
    // sample stream
    output logic [dpis_pkg::DATA_W-1:0] src_data,
    output logic src_valid,
    input wire logic src_ready,
    // sleep pin
    output logic sleep_in,
    output logic sleep_drive_en
);
    initial begin
        src_data = 14'h0000;
        src_valid = 1'b0;
        sleep_in = 1'b0;
        sleep_drive_en = 1'b0;
    end

    // valid stays up on return, so words can follow back to back
    task automatic put(input logic [dpis_pkg::DATA_W-1:0] w);
        src_data = w;
        src_valid = 1'b1;
        // ready is settled at the falling edge before the capture edge
        while (src_ready !== 1'b1) begin
            @(posedge clk);
            @(negedge clk);
        end
        @(posedge clk);
        @(negedge clk);
    endtask : put

    // released bus shows no stale word
    task automatic idle;
        src_valid = 1'b0;
        src_data = ~src_data;
    endtask : idle

    task automatic pin(input logic v, input logic en);
        sleep_in = v;
        sleep_drive_en = en;
    endtask : pin
endmodule : dpis_source
`default_nettype wire

// ===== bench/testbench.sv
/*
 * Self-checking bench for dpis_top: a table of words, then sleep, fill,
 * wake and reset cases. Assumes the source model dpis_source.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int W = dpis_pkg::DATA_W;
    typedef struct packed {
        logic [W-1:0] w;
        logic [W-1:0] t;
        logic [W-1:0] c;
    } dpis_row_t;
    logic clk;
    logic rst_b;
    logic [W-1:0] src_data;
    logic src_valid;
    logic src_ready;
    logic sleep_in;
    logic sleep_drive_en;
    logic [W-1:0] tco;
    logic [W-1:0] cco;
    logic output_enabled;
    logic low_power;
    logic sample_valid;
    wire logic [3:0] flg;
    int err_total;
    int num_checks;
    int idx;
    dpis_row_t rows [6];

    assign flg = {output_enabled, low_power, sample_valid, src_ready};
    always #50 clk = ~clk;

    dpis_top i_dpis_top (.clk(clk), .rst_b(rst_b), .src_data(src_data),
        .src_valid(src_valid), .src_ready(src_ready), .sleep_in(sleep_in),
        .sleep_drive_en(sleep_drive_en), .true_current_output(tco),
        .complement_current_output(cco), .output_enabled(output_enabled),
        .low_power(low_power), .sample_valid(sample_valid));

    dpis_source i_dpis_source (.clk(clk), .src_data(src_data), .src_valid(src_valid),
        .src_ready(src_ready), .sleep_in(sleep_in), .sleep_drive_en(sleep_drive_en));

    task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        err_total = 0;
        num_checks = 0;
        rows = '{'{14'h3fff, 14'h3fff, 14'h0000}, '{14'h0000, 14'h0000, 14'h3fff},
            '{14'h2000, 14'h2000, 14'h1fff}, '{14'h0001, 14'h0001, 14'h3ffe},
            '{14'h2aaa, 14'h2aaa, 14'h1555}, '{14'h1555, 14'h1555, 14'h2aaa}};
        repeat (12) @(negedge clk);
        chk(tco, 14'h0000, "reset true");
        chk(cco, 14'h3fff, "reset complement");
        chk(W'(flg), 14'h0009, "reset flags");
        rst_b = 1'b1;
        repeat (49) @(negedge clk);
        chk(W'(sample_valid), 14'h0000, "still waking");
        @(negedge clk);
        chk(W'(sample_valid), 14'h0001, "awake");
        $display("test reset_wake done");
        foreach (rows[i]) begin
            i_dpis_source.put(rows[i].w);
            i_dpis_source.idle();
            @(negedge clk);
            chk(tco, rows[i].t, "true code");
            chk(cco, rows[i].c, "complement code");
            // bus toggles with valid low between captures
            repeat (2) begin
                i_dpis_source.idle();
                @(negedge clk);
            end
            chk(tco, rows[i].t, "held code");
        end
        $display("test table done");
        i_dpis_source.put(14'h1234);
        i_dpis_source.put(14'h0fed);
        chk(tco, 14'h1234, "first of pair");
        i_dpis_source.idle();
        @(negedge clk);
        chk(tco, 14'h0fed, "second of pair");
        $display("test back_to_back done");
        i_dpis_source.pin(1'b1, 1'b1);
        repeat (2) @(negedge clk);
        chk(W'(flg[3]), 14'h0001, "not yet asleep");
        @(negedge clk);
        chk(W'(flg[3:1]), 14'h0002, "asleep flags");
        chk(tco | cco, 14'h0000, "currents off");
        for (int k = 0; k < 32; k++) i_dpis_source.put(14'h0100 + W'(k));
        chk(W'(src_ready), 14'h0000, "full while asleep");
        i_dpis_source.idle();
        i_dpis_source.pin(1'b0, 1'b1);
        idx = 0;
        for (int c = 1; c <= 53; c++) begin
            @(negedge clk);
            if (c == 3) chk(W'(flg[3:1]), 14'h0004, "wake flags");
            if (c == 52) chk(W'(sample_valid), 14'h0000, "invalid in wake");
            if (tco === 14'h0100 + W'(idx)) idx++;
        end
        chk(W'(flg), 14'h000b, "active again");
        chk(W'(idx), 14'h0020, "drained in order");
        chk(cco, 14'h3ee0, "last complement");
        $display("test sleep_fill_wake done");
        i_dpis_source.pin(1'b1, 1'b0);
        repeat (5) @(negedge clk);
        chk(W'(flg), 14'h000b, "open pin stays awake");
        i_dpis_source.pin(1'b0, 1'b0);
        $display("test open_pin done");
        i_dpis_source.pin(1'b1, 1'b1);
        repeat (3) @(negedge clk);
        i_dpis_source.pin(1'b0, 1'b1);
        repeat (8) @(negedge clk);
        chk(W'(flg[3:1]), 14'h0004, "in wake");
        i_dpis_source.pin(1'b1, 1'b1);
        repeat (3) @(negedge clk);
        chk(W'(flg[3:1]), 14'h0002, "sleep cuts wake");
        chk(tco | cco, 14'h0000, "wake cut off");
        i_dpis_source.pin(1'b0, 1'b0);
        $display("test sleep_in_wake done");
        rst_b = 1'b0;
        @(negedge clk);
        chk(tco, 14'h0000, "mid reset true");
        chk(W'(flg), 14'h0009, "mid reset flags");
        chk(cco, 14'h3fff, "mid reset complement");
        repeat (11) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        chk(W'(sample_valid), 14'h0000, "waking after reset");
        chk(W'(flg), 14'h0009, "flags after reset");
        $display("test mid_reset done");
        summarize();
    end

    // whole run needs about 210 cycles
    initial begin
        repeat (4000) @(posedge clk);
        err_total++;
        $display("ERROR at %0t: watchdog expired", $time);
        summarize();
    end
endmodule : testbench
`default_nettype wire
